// ### fwd_pkg.sv
// constants and types shared by the forwarding engine files
package fwd_pkg;
  // ==========================================
  // sizes
  localparam int NPORT = 4;
  localparam int NTX = 2;
  localparam int DW = 8;
  localparam int WW = 11;
  localparam int FIFO_DEPTH = 16;
  localparam int BUF_BYTES = 16384;
  // ==========================================
  // register offsets and reset values
  localparam logic [7:0] ADDR_PORT_MAP = 8'h20;
  localparam logic [7:0] ADDR_MODE = 8'h21;
  localparam logic [7:0] ADDR_STATUS = 8'h22;
  localparam logic [7:0] ADDR_VC = 8'h23;
  localparam logic [7:0] PORT_MAP_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h03;
  localparam logic [7:0] VC_RST = 8'he4;
  // ==========================================
  // field positions
  localparam int MAP_LSB = 4;
  localparam int DIS_LSB = 0;
  localparam int RR_LSB = 0;
  localparam int SYNC_LSB = 2;
  localparam int W_LAST = 10;
  localparam int W_KIND = 8;
  // ==========================================
  // packet kinds and synchronized mode codes
  localparam logic [1:0] KIND_LINE = 2'h0;
  localparam logic [1:0] KIND_FS = 2'h1;
  localparam logic [1:0] KIND_FE = 2'h2;
  localparam logic [1:0] SYNC_OFF = 2'h0;
  localparam logic [1:0] SYNC_BASIC = 2'h1;
  localparam logic [1:0] SYNC_ILV = 2'h2;
  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SYNC_WINDOW_NS = 20000;
  localparam logic [11:0] SYNC_WAIT_CYC = 12'(SYNC_WINDOW_NS / CLK_PERIOD_NS);
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_DROP} eng_state_t;
endpackage : fwd_pkg

// ### fwd_engine.sv
// per-port video buffers and the two csi-2 forwarding engines

// ==========================================
// fifo
module fwd_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  // depth must be a power of two: pointers wrap freely
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_o = count_reg != (AW+1)'(DEPTH);
  assign out_valid_o = count_reg != '0;
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && out_valid_o;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : fwd_fifo

// ==========================================
// top
module csi2_stream_forwarding_engine (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic rx_clk_i,
  input wire logic rx_valid_i,
  input wire logic rx_last_i,
  input wire logic [1:0] rx_kind_i,
  input wire logic [1:0] rx_port_i,
  input wire logic [7:0] rx_data_i,
  output logic [3:0] rx_ready_o,
  input wire logic [1:0] tx_ready_i,
  output logic [1:0] tx_valid_o,
  output logic [1:0] tx_last_o,
  output logic [1:0][1:0] tx_kind_o,
  output logic [1:0][1:0] tx_vc_o,
  output logic [1:0][7:0] tx_data_o,
  output logic [1:0] tx_hs_o
);
  localparam int NP = fwd_pkg::NPORT;
  localparam int NT = fwd_pkg::NTX;
  localparam int WW_T = fwd_pkg::WW;

  function automatic logic [2:0] rr_pick(input logic [3:0] mask, input logic [1:0] start);
    logic [2:0] res;
    logic [1:0] j;
    res = 3'h0;
    for (int i = 3; i >= 0; i--)
    begin
      j = start + 2'(i);
      if (mask[j])
      begin
        res = {1'b1, j};
      end
    end
    return res;
  endfunction : rr_pick

  function automatic logic [3:0] own_mask(input logic [7:0] map, input int e);
    logic [3:0] m;
    m = 4'h0;
    for (int p = 0; p < 4; p++)
    begin
      m[p] = (int'(map[fwd_pkg::MAP_LSB + p]) == e) && !map[fwd_pkg::DIS_LSB + p];
    end
    return m;
  endfunction : own_mask

  logic [7:0] port_map_reg;
  logic [7:0] mode_reg;
  logic [7:0] vc_reg;
  logic [7:0] rdata_reg;
  logic [14:0] s1_reg;
  logic [14:0] s2_reg;
  logic clk_d_reg;
  logic [3:0] rx_ready_reg;
  logic [4:0] pkt_cnt_reg [NP];
  fwd_pkg::eng_state_t state_reg [NT];
  logic [1:0] cur_reg [NT];
  logic [1:0] rr_last_reg [NT];
  logic [1:0] gk_reg [NT];
  logic [11:0] wait_cnt_reg [NT];
  logic [1:0] synced_reg;
  logic [1:0] lost_reg;
  logic [1:0] tx_valid_reg;
  logic [1:0] tx_last_reg;
  logic [1:0][1:0] tx_kind_reg;
  logic [1:0][1:0] tx_vc_reg;
  logic [1:0][7:0] tx_data_reg;
  logic [1:0] tx_hs_reg;
  logic rise;
  logic [3:0] wr_valid;
  logic [3:0] fifo_in_ready;
  logic [3:0] fifo_valid;
  logic [3:0] pop;
  logic [3:0] avail;
  logic [3:0] fs_head;
  logic [WW_T-1:0] fifo_data [NP];
  logic [3:0] own_m [NT];
  logic [2:0] lowest [NT];
  logic [2:0] rr_next [NT];
  logic [2:0] hunt [NT];
  logic [2:0] advance [NT];
  logic [1:0] sync_sel [NT];
  logic [1:0] head_k [NT];
  logic [1:0] load;
  logic [1:0] dpop;
  logic [1:0] loss;
  logic [1:0] first;
  logic [1:0] kind_ok;
  logic [1:0] out_free;
  logic status_rd;

  // ==========================================
  // registers
  assign status_rd = reg_rd_i && reg_addr_i == fwd_pkg::ADDR_STATUS;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      port_map_reg <= fwd_pkg::PORT_MAP_RST;
      mode_reg <= fwd_pkg::MODE_RST;
      vc_reg <= fwd_pkg::VC_RST;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == fwd_pkg::ADDR_PORT_MAP)
      begin
        port_map_reg <= reg_wdata_i;
      end
      else if (reg_addr_i == fwd_pkg::ADDR_MODE)
      begin
        mode_reg <= reg_wdata_i;
      end
      else if (reg_addr_i == fwd_pkg::ADDR_VC)
      begin
        vc_reg <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_reg <= 8'h00;
    end
    else if (reg_rd_i)
    begin
      if (reg_addr_i == fwd_pkg::ADDR_PORT_MAP)
      begin
        rdata_reg <= port_map_reg;
      end
      else if (reg_addr_i == fwd_pkg::ADDR_MODE)
      begin
        rdata_reg <= mode_reg;
      end
      else if (status_rd)
      begin
        rdata_reg <= {4'h0, lost_reg, synced_reg};
      end
      else if (reg_addr_i == fwd_pkg::ADDR_VC)
      begin
        rdata_reg <= vc_reg;
      end
      else
      begin
        rdata_reg <= 8'h00;
      end
    end
  end

  // a new loss in the read cycle survives the clear
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lost_reg <= 2'h0;
    end
    else
    begin
      lost_reg <= loss | (lost_reg & {2{!status_rd}});
    end
  end

  // ==========================================
  // receive link sampling
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      clk_d_reg <= 1'b0;
      rx_ready_reg <= 4'h0;
    end
    else
    begin
      s1_reg <= {rx_clk_i, rx_valid_i, rx_last_i, rx_kind_i, rx_port_i, rx_data_i};
      s2_reg <= s1_reg;
      clk_d_reg <= s2_reg[14];
      rx_ready_reg <= fifo_in_ready;
    end
  end

  assign rise = s2_reg[14] && !clk_d_reg;

  // ==========================================
  // per-port buffers and whole-packet counts
  for (genvar p = 0; p < NP; p++)
  begin : g_buf
    assign wr_valid[p] = rise && s2_reg[13] && s2_reg[9:8] == 2'(p);
    assign avail[p] = pkt_cnt_reg[p] != 5'h00;
    assign fs_head[p] = avail[p] && fifo_data[p][fwd_pkg::W_KIND +: 2] == fwd_pkg::KIND_FS;

    fwd_fifo #(.WIDTH(WW_T), .DEPTH(fwd_pkg::FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(wr_valid[p]),
      .in_ready_o(fifo_in_ready[p]),
      .in_data_i({s2_reg[12:10], s2_reg[7:0]}),
      .out_valid_o(fifo_valid[p]),
      .out_ready_i(pop[p]),
      .out_data_o(fifo_data[p])
    );

    always_ff @(posedge clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        pkt_cnt_reg[p] <= 5'h00;
      end
      else
      begin
        pkt_cnt_reg[p] <= pkt_cnt_reg[p]
          + 5'(wr_valid[p] && fifo_in_ready[p] && s2_reg[12])
          - 5'(pop[p] && fifo_data[p][fwd_pkg::W_LAST]);
      end
    end
  end

  // ==========================================
  // engine decisions
  always_comb
  begin
    pop = 4'h0;
    for (int e = 0; e < NT; e++)
    begin
      own_m[e] = own_mask(port_map_reg, e);
      sync_sel[e] = mode_reg[fwd_pkg::SYNC_LSB + 2*e +: 2];
      lowest[e] = rr_pick(own_m[e], 2'h0);
      rr_next[e] = rr_pick(own_m[e] & avail, rr_last_reg[e] + 2'h1);
      hunt[e] = rr_pick(own_m[e] & avail & ~fs_head, 2'h0);
      advance[e] = rr_pick(own_m[e], cur_reg[e] + 2'h1);
      head_k[e] = fifo_data[cur_reg[e]][fwd_pkg::W_KIND +: 2];
      first[e] = cur_reg[e] == lowest[e][1:0];
      kind_ok[e] = first[e] || head_k[e] == gk_reg[e];
      // a held last word leaves before the next packet loads: one idle cycle between packets
      out_free[e] = !tx_valid_reg[e] || (tx_ready_i[e] && !tx_last_reg[e]);
      load[e] = state_reg[e] == fwd_pkg::ST_SEND && out_free[e] && fifo_valid[cur_reg[e]]
        && int'(port_map_reg[fwd_pkg::MAP_LSB + cur_reg[e]]) == e;
      dpop[e] = state_reg[e] == fwd_pkg::ST_DROP && fifo_valid[cur_reg[e]];
      loss[e] = state_reg[e] == fwd_pkg::ST_IDLE && sync_sel[e] != fwd_pkg::SYNC_OFF && synced_reg[e]
        && (avail[cur_reg[e]] ? !kind_ok[e] : wait_cnt_reg[e] == fwd_pkg::SYNC_WAIT_CYC - 12'h001);
      if (load[e] || dpop[e])
      begin
        pop[cur_reg[e]] = 1'b1;
      end
    end
  end

  // ==========================================
  // engine state
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      synced_reg <= 2'h0;
      for (int e = 0; e < NT; e++)
      begin
        state_reg[e] <= fwd_pkg::ST_IDLE;
        cur_reg[e] <= 2'h0;
        rr_last_reg[e] <= 2'h3;
        gk_reg[e] <= 2'h0;
        wait_cnt_reg[e] <= 12'h000;
      end
    end
    else
    begin
      for (int e = 0; e < NT; e++)
      begin
        case (state_reg[e])
          fwd_pkg::ST_IDLE:
          begin
            wait_cnt_reg[e] <= 12'h000;
            if (sync_sel[e] == fwd_pkg::SYNC_OFF)
            begin
              synced_reg[e] <= 1'b0;
              if (mode_reg[fwd_pkg::RR_LSB + e] && rr_next[e][2])
              begin
                cur_reg[e] <= rr_next[e][1:0];
                rr_last_reg[e] <= rr_next[e][1:0];
                state_reg[e] <= fwd_pkg::ST_SEND;
              end
            end
            else if (!synced_reg[e])
            begin
              // hunting: throw away all but frame starts until every enabled port of this engine holds one
              if (hunt[e][2])
              begin
                cur_reg[e] <= hunt[e][1:0];
                state_reg[e] <= fwd_pkg::ST_DROP;
              end
              else if (own_m[e] != 4'h0 && (own_m[e] & avail) == own_m[e])
              begin
                synced_reg[e] <= 1'b1;
                cur_reg[e] <= lowest[e][1:0];
              end
            end
            else if (loss[e])
            begin
              synced_reg[e] <= 1'b0;
            end
            else if (!avail[cur_reg[e]])
            begin
              wait_cnt_reg[e] <= wait_cnt_reg[e] + 12'h001;
            end
            else
            begin
              if (first[e])
              begin
                gk_reg[e] <= head_k[e];
              end
              if (sync_sel[e] >= fwd_pkg::SYNC_ILV && !first[e] && head_k[e] != fwd_pkg::KIND_LINE)
              begin
                state_reg[e] <= fwd_pkg::ST_DROP;
              end
              else
              begin
                state_reg[e] <= fwd_pkg::ST_SEND;
              end
            end
          end
          fwd_pkg::ST_SEND, fwd_pkg::ST_DROP:
          begin
            if ((load[e] || dpop[e]) && fifo_data[cur_reg[e]][fwd_pkg::W_LAST])
            begin
              state_reg[e] <= fwd_pkg::ST_IDLE;
              if (synced_reg[e])
              begin
                cur_reg[e] <= advance[e][1:0];
              end
            end
          end
          default:
          begin
            state_reg[e] <= fwd_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================
  // transmit output stage
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_valid_reg <= 2'h0;
      tx_last_reg <= 2'h0;
      tx_kind_reg <= '0;
      tx_vc_reg <= '0;
      tx_data_reg <= '0;
      tx_hs_reg <= 2'h0;
    end
    else
    begin
      for (int e = 0; e < NT; e++)
      begin
        // hs held for the whole packet and its last word in flight
        tx_hs_reg[e] <= state_reg[e] == fwd_pkg::ST_SEND || tx_valid_reg[e];
        if (load[e])
        begin
          tx_valid_reg[e] <= 1'b1;
          tx_last_reg[e] <= fifo_data[cur_reg[e]][fwd_pkg::W_LAST];
          tx_kind_reg[e] <= fifo_data[cur_reg[e]][fwd_pkg::W_KIND +: 2];
          tx_data_reg[e] <= fifo_data[cur_reg[e]][7:0];
          tx_vc_reg[e] <= vc_reg[2*cur_reg[e] +: 2];
        end
        else if (tx_ready_i[e])
        begin
          tx_valid_reg[e] <= 1'b0;
        end
      end
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign rx_ready_o = rx_ready_reg;
  assign tx_valid_o = tx_valid_reg;
  assign tx_last_o = tx_last_reg;
  assign tx_kind_o = tx_kind_reg;
  assign tx_vc_o = tx_vc_reg;
  assign tx_data_o = tx_data_reg;
  assign tx_hs_o = tx_hs_reg;
endmodule : csi2_stream_forwarding_engine

// ### fwd_monitor.sv
// checker of the forwarding engine port behaviour
module fwd_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [1:0] tx_ready_i,
  input wire logic [1:0] tx_valid_o,
  input wire logic [1:0] tx_last_o,
  input wire logic [1:0][1:0] tx_kind_o,
  input wire logic [1:0][1:0] tx_vc_o,
  input wire logic [1:0][7:0] tx_data_o,
  input wire logic [1:0] tx_hs_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================
  // transmit words
  AST_HOLD0: assert property (tx_valid_o[0] && !tx_ready_i[0] |=> tx_valid_o[0] && $stable(tx_data_o[0]))
    else $error("tx0 word changed before accept");
  AST_HOLD1: assert property (tx_valid_o[1] && !tx_ready_i[1] |=> tx_valid_o[1] && $stable(tx_last_o[1]))
    else $error("tx1 word changed before accept");
  AST_HS: assert property (tx_valid_o[0] || tx_valid_o[1] |-> (tx_valid_o & ~tx_hs_o) == 2'h0)
    else $error("word sent outside high speed");
  AST_GAP0: assert property (tx_valid_o[0] && tx_ready_i[0] && tx_last_o[0] |=> !tx_valid_o[0])
    else $error("no idle cycle after tx0 packet");
  AST_BURST0: assert property (tx_valid_o[0] && tx_ready_i[0] && !tx_last_o[0]
    |=> tx_valid_o[0] && $stable(tx_vc_o[0]) && $stable(tx_kind_o[0]))
    else $error("tx0 packet broken mid-way");
  // ==========================================
  // registers and reset
  AST_MAP_RD: assert property (reg_wr_i && reg_addr_i == 8'h20 ##1 reg_rd_i && reg_addr_i == 8'h20
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("map write not read back");
  AST_MODE_RD: assert property (reg_wr_i && reg_addr_i == 8'h21 ##1 reg_rd_i && reg_addr_i == 8'h21
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("mode write not read back");
  AST_RST_IDLE: assert property ($fell(rst_i) |-> (tx_valid_o == 2'h0)[*3])
    else $error("word sent right after reset");
  AST_RD_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
endmodule : fwd_monitor

bind csi2_stream_forwarding_engine fwd_monitor mon (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .tx_ready_i, .tx_valid_o, .tx_last_o, .tx_kind_o, .tx_vc_o, .tx_data_o, .tx_hs_o);

// ### video_sink_model.sv
// downstream video processor model for one transmit lane
module video_sink_model #(
  parameter bit SLOW = 1'b0
) (
  input wire logic clk_i,
  input wire logic valid_i,
  input wire logic last_i,
  input wire logic [1:0] kind_i,
  input wire logic [1:0] vc_i,
  input wire logic [7:0] data_i,
  output logic ready_o
);
  // ==========================================
  // capture: one entry per packet, vc kind length first byte
  logic [15:0] q[$];
  logic [15:0] cur = 16'h0000;
  logic [7:0] prev = 8'h00;
  int cnt = 0;
  int bad = 0;
  initial ready_o = 1'b1;
  // slow lane takes a word every other cycle so held words get exercised
  always @(posedge clk_i)
  begin
    if (SLOW)
      ready_o <= ~ready_o;
    if (valid_i && ready_o)
    begin
      if (cnt == 0)
        cur = {vc_i, kind_i, 4'h0, data_i};
      else if (data_i !== prev + 8'h01)
        bad++;
      cur[11:8] = cur[11:8] + 4'h1;
      prev = data_i;
      cnt = last_i ? 0 : cnt + 1;
      if (last_i)
        q.push_back(cur);
    end
  end
endmodule : video_sink_model

// ### csi2_stream_forwarding_engine_tb.sv
// self-checking bench for the csi-2 forwarding engine
module csi2_stream_forwarding_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic rx_clk_i = 1'b0;
  logic rx_valid_i = 1'b0;
  logic rx_last_i = 1'b0;
  logic [1:0] rx_kind_i = 2'h0;
  logic [1:0] rx_port_i = 2'h0;
  logic [7:0] rx_data_i = 8'h00;
  logic [3:0] rx_ready_o;
  wire [1:0] tx_ready_i;
  logic [1:0] tx_valid_o;
  logic [1:0] tx_last_o;
  logic [1:0][1:0] tx_kind_o;
  logic [1:0][1:0] tx_vc_o;
  logic [1:0][7:0] tx_data_o;
  logic [1:0] tx_hs_o;
  logic [7:0] rst_a [5] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h30};
  logic [7:0] rst_v [5] = '{8'h00, 8'h03, 8'h00, 8'he4, 8'h00};
  logic [1:0] fr_kind [3] = '{2'h1, 2'h0, 2'h2};
  int fr_len [3] = '{1, 2, 1};
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  always #4 clk_i = ~clk_i;
  // ==========================================
  // instances
  csi2_stream_forwarding_engine dut (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .rx_clk_i, .rx_valid_i, .rx_last_i, .rx_kind_i, .rx_port_i, .rx_data_i, .rx_ready_o,
    .tx_ready_i, .tx_valid_o, .tx_last_o, .tx_kind_o, .tx_vc_o, .tx_data_o, .tx_hs_o);
  video_sink_model #(.SLOW(1'b1)) sink0 (.clk_i, .valid_i(tx_valid_o[0]), .last_i(tx_last_o[0]),
    .kind_i(tx_kind_o[0]), .vc_i(tx_vc_o[0]), .data_i(tx_data_o[0]), .ready_o(tx_ready_i[0]));
  video_sink_model #(.SLOW(1'b0)) sink1 (.clk_i, .valid_i(tx_valid_o[1]), .last_i(tx_last_o[1]),
    .kind_i(tx_kind_o[1]), .vc_i(tx_vc_o[1]), .data_i(tx_data_o[1]), .ready_o(tx_ready_i[1]));
  // ==========================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // every write is read straight back, so each one also checks the access kind
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk({8'h00, reg_rdata_o}, {8'h00, d});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk({8'h00, reg_rdata_o}, {8'h00, exp});
  endtask : rd

  // link clock runs only inside a packet and stands still low between them
  task automatic send_pkt(input logic [1:0] p, input logic [1:0] k, input int n, input logic [7:0] d0);
    @(negedge clk_i);
    while (rx_ready_o[p] !== 1'b1)
      @(negedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      rx_valid_i = 1'b1;
      rx_port_i = p;
      rx_kind_i = k;
      rx_last_i = (i == n - 1);
      rx_data_i = d0 + 8'(i);
      repeat (10) @(negedge clk_i);
      rx_clk_i = 1'b1;
      repeat (10) @(negedge clk_i);
      rx_clk_i = 1'b0;
    end
    rx_valid_i = 1'b0;
    rx_data_i = ~rx_data_i;
  endtask : send_pkt

  task automatic send_frame();
    for (int k = 0; k < 3; k++)
      for (int p = 3; p >= 0; p--)
        send_pkt(2'(p), fr_kind[k], fr_len[k], 8'(16 * k + 4 * p));
  endtask : send_frame

  task automatic wait_pkts(input int t, input int n);
    repeat (3000)
    begin
      if ((t == 0 ? sink0.q.size() : sink1.q.size()) >= n)
        return;
      @(negedge clk_i);
    end
    chk(16'h0000, 16'h0001);
  endtask : wait_pkts

  task automatic exp_pkt(input int t, input logic [1:0] vc, input logic [1:0] k, input logic [3:0] n,
    input logic [7:0] d0);
    logic [15:0] e;
    e = 16'hffff;
    if (t == 0 && sink0.q.size() > 0)
      e = sink0.q.pop_front();
    if (t == 1 && sink1.q.size() > 0)
      e = sink1.q.pop_front();
    chk(e, {vc, k, n, d0});
  endtask : exp_pkt

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  // ==========================================
  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      $display("[ERR] %0t run did not finish in time", $time);
      n_mismatch++;
      conclude();
    end
  end
  // ==========================================
  // sequence
  initial
  begin
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 5; i++)
      rd(rst_a[i], rst_v[i]);
    wr(8'h20, 8'h24);
    send_pkt(2'h1, 2'h0, 3, 8'h50);
    send_pkt(2'h2, 2'h0, 1, 8'h60);
    wait_pkts(1, 1);
    exp_pkt(1, 2'h1, 2'h0, 4'h3, 8'h50);
    repeat (100) @(negedge clk_i);
    chk(16'(sink0.q.size()), 16'h0000);
    wr(8'h20, 8'h00);
    wait_pkts(0, 1);
    exp_pkt(0, 2'h2, 2'h0, 4'h1, 8'h60);
    // all four pending at once; port 2 went last, so service resumes at 3
    wr(8'h20, 8'h0f);
    for (int i = 0; i < 4; i++)
      send_pkt(2'(i * 2 + i / 2), 2'h0, 2, 8'(16 * i));
    wr(8'h20, 8'h00);
    wait_pkts(0, 4);
    for (int i = 0; i < 4; i++)
      exp_pkt(0, 2'(3 + i), 2'h0, 4'h2, 8'(16 * ((3 + i) % 4 == 1 ? 2 : (3 + i) % 4 == 2 ? 1 :
        (3 + i) % 4)));
    wr(8'h21, 8'h00);
    wr(8'h20, 8'h00);
    wr(8'h21, 8'h04);
    send_frame();
    wait_pkts(0, 12);
    rd(8'h22, 8'h01);
    for (int k = 0; k < 3; k++)
      for (int p = 0; p < 4; p++)
        exp_pkt(0, 2'(p), fr_kind[k], 4'(fr_len[k]), 8'(16 * k + 4 * p));
    wr(8'h23, 8'h00);
    wr(8'h21, 8'h08);
    send_frame();
    wait_pkts(0, 6);
    exp_pkt(0, 2'h0, 2'h1, 4'h1, 8'h00);
    for (int p = 0; p < 4; p++)
      exp_pkt(0, 2'h0, 2'h0, 4'h2, 8'(16 + 4 * p));
    exp_pkt(0, 2'h0, 2'h2, 4'h1, 8'h20);
    repeat (50) @(negedge clk_i);
    chk(16'(sink0.q.size()), 16'h0000);
    // a lone frame start: the wait for port 1 runs out
    send_pkt(2'h0, 2'h1, 1, 8'h70);
    repeat (3000) @(negedge clk_i);
    rd(8'h22, 8'h04);
    rd(8'h22, 8'h00);
    // the lone start still went out before the wait for port 1 began
    exp_pkt(0, 2'h0, 2'h1, 4'h1, 8'h70);
    send_pkt(2'h1, 2'h0, 2, 8'h78);
    repeat (200) @(negedge clk_i);
    chk(16'(sink0.q.size()), 16'h0000);
    // buffer: fill port 3 while it is cut off, then drain it in order through transmitter 0
    wr(8'h20, 8'h08);
    send_pkt(2'h3, 2'h0, 16, 8'h80);
    chk(16'(rx_ready_o), 16'h0007);
    wr(8'h21, 8'h01);
    wr(8'h20, 8'h00);
    wait_pkts(0, 1);
    // sixteen words wrap the model's 4-bit length field to zero
    exp_pkt(0, 2'h0, 2'h0, 4'h0, 8'h80);
    chk(16'(rx_ready_o), 16'h000f);
    chk(16'(sink0.bad + sink1.bad), 16'h0000);
    conclude();
  end
endmodule : csi2_stream_forwarding_engine_tb
